// ===== hdl/pwmps_pkg.sv
// Package: register map, field positions and reset values of the period block
package pwmps_pkg;
   localparam int          PWMPS_DATA_W      = 32;
   localparam int          PWMPS_PERIOD_W    = 16;
   // Register byte offsets
   localparam logic [11:0] PWMPS_OFS_PERIOD  = 12'h000;
   localparam logic [11:0] PWMPS_OFS_CONTROL = 12'h004;
   localparam logic [11:0] PWMPS_OFS_COUNTER = 12'h008;
   // Control field positions
   localparam int          PWMPS_CTL_LDSEL   = 0;
   localparam int          PWMPS_CTL_RUN     = 1;
   // Reset values
   localparam logic [15:0] PWMPS_PERIOD_RST  = 16'h0000;
   localparam logic        PWMPS_LDSEL_RST   = 1'b0;
   localparam logic        PWMPS_RUN_RST     = 1'b0;
endpackage

// ===== hdl/pwmps_counter.sv
// Up-counting time base that wraps when it reaches the active period
`timescale 1ns/1ps
`default_nettype none
module pwmps_counter
   import pwmps_pkg::*;
#(
   parameter int PERIOD_W = PWMPS_PERIOD_W
)
(
   // Clock, reset and enable
   input  wire logic                clk_sys_i,
   input  wire logic                rst_n_i,
   input  wire logic                ce_i,
   // Control
   input  wire logic                run_i,
   input  wire logic [PERIOD_W-1:0] period_i,
   // Status
   output logic      [PERIOD_W-1:0] count_o,
   output logic                     zero_o
);
   typedef struct packed {
      logic [PERIOD_W-1:0] count;
   } pwmps_cnt_state_t;

   pwmps_cnt_state_t state;
   pwmps_cnt_state_t next_state;

   always_comb
   begin
      next_state = state;
      if (ce_i && run_i)
      begin
         // Compare every cycle with ce_i and run_i high; equal or above ends the period
         if (state.count >= period_i)
         begin
            next_state.count = '0;
         end
         else
         begin
            next_state.count = state.count + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign count_o = state.count;
   assign zero_o  = (state.count == '0);

   a_period_end : assert property (
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && run_i && state.count == period_i) |=> state.count == '0)
      else $error("counter did not wrap at period");
endmodule
`default_nettype wire

// ===== hdl/pwmps_top.sv
// Double-buffered time-base period register with APB slave and time base
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module pwmps_top
   import pwmps_pkg::*;
#(
   parameter int ADDR_W   = 12,
   parameter int PERIOD_W = PWMPS_PERIOD_W
)
(
   // Clock, reset and enable
   input  wire logic                    clk_sys_i,
   input  wire logic                    resetn_i,
   input  wire logic                    ce_i,
   // APB slave
   input  wire logic                    psel_i,
   input  wire logic                    penable_i,
   input  wire logic                    pwrite_i,
   input  wire logic [ADDR_W-1:0]       paddr_i,
   input  wire logic [PWMPS_DATA_W-1:0] pwdata_i,
   output logic      [PWMPS_DATA_W-1:0] prdata_o,
   output logic                         pready_o,
   output logic                         pslverr_o,
   // Time base status
   output logic      [PERIOD_W-1:0]     active_period_o,
   output logic      [PERIOD_W-1:0]     count_o,
   output logic                         count_zero_o
);
   typedef struct packed {
      logic [PERIOD_W-1:0]     shadow;
      logic [PERIOD_W-1:0]     active;
      logic                    load_select;
      logic                    run;
      logic [PWMPS_DATA_W-1:0] rdata;
      logic                    rd_valid;
   } pwmps_state_t;

   pwmps_state_t state;
   pwmps_state_t next_state;

   logic                rst_sync1;
   logic                rst_n;
   logic [PERIOD_W-1:0] count;
   logic                count_zero;
   logic                setup;
   logic                access;
   logic                wr_en;
   logic [11:0]         addr_ofs;

   // Release through two flops so state leaves reset on a clean edge
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         rst_sync1 <= 1'b0;
         rst_n     <= 1'b0;
      end
      else
      begin
         rst_sync1 <= 1'b1;
         rst_n     <= rst_sync1;
      end
   end

   function automatic logic pwmps_mapped(input logic [11:0] ofs);
      pwmps_mapped = (ofs == PWMPS_OFS_PERIOD)  ||
                     (ofs == PWMPS_OFS_CONTROL) ||
                     (ofs == PWMPS_OFS_COUNTER);
   endfunction

   assign addr_ofs = 12'(paddr_i);
   assign setup    = psel_i && !penable_i;
   assign access   = psel_i && penable_i;
   // Frozen enable stalls the bus too, so no write is lost;
   // a read waits until its data has really been captured
   assign pready_o = ce_i && (pwrite_i || state.rd_valid);
   assign pslverr_o = access && !pwmps_mapped(addr_ofs);
   assign wr_en    = access && pwrite_i && ce_i && pwmps_mapped(addr_ofs);

   always_comb
   begin
      next_state = state;
      if (ce_i)
      begin
         // Shadow moves to active on counter zero, before any bus write
         if (!state.load_select && count_zero)
         begin
            next_state.active = state.shadow;
         end
         // Captured in setup, or late if enable froze the setup edge
         if (psel_i && !pwrite_i && !state.rd_valid)
         begin
            next_state.rd_valid = 1'b1;
            unique case (addr_ofs)
               PWMPS_OFS_PERIOD:
               begin
                  // One address, copy chosen by load select
                  next_state.rdata = PWMPS_DATA_W'(state.load_select ?
                                     state.active : state.shadow);
               end
               PWMPS_OFS_CONTROL:
               begin
                  next_state.rdata = '0;
                  next_state.rdata[PWMPS_CTL_LDSEL] = state.load_select;
                  next_state.rdata[PWMPS_CTL_RUN]   = state.run;
               end
               PWMPS_OFS_COUNTER:
               begin
                  next_state.rdata = PWMPS_DATA_W'(count);
               end
               default:
               begin
                  next_state.rdata = '0;
               end
            endcase
         end
         if (access && pready_o)
         begin
            next_state.rd_valid = 1'b0;
         end
         if (wr_en)
         begin
            unique case (addr_ofs)
               PWMPS_OFS_PERIOD:
               begin
                  if (state.load_select)
                  begin
                     next_state.active = pwdata_i[PERIOD_W-1:0];
                  end
                  else
                  begin
                     next_state.shadow = pwdata_i[PERIOD_W-1:0];
                  end
               end
               PWMPS_OFS_CONTROL:
               begin
                  next_state.load_select = pwdata_i[PWMPS_CTL_LDSEL];
                  next_state.run         = pwdata_i[PWMPS_CTL_RUN];
               end
               default:
               begin
                  next_state.run = state.run;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state.shadow      <= PWMPS_PERIOD_RST;
         state.active      <= PWMPS_PERIOD_RST;
         state.load_select <= PWMPS_LDSEL_RST;
         state.run         <= PWMPS_RUN_RST;
         state.rdata       <= '0;
         state.rd_valid    <= 1'b0;
      end
      else
      begin
         state <= next_state;
      end
   end

   pwmps_counter #(
      .PERIOD_W (PERIOD_W)
   ) u_counter (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n),
      .ce_i      (ce_i),
      .run_i     (state.run),
      .period_i  (state.active),
      .count_o   (count),
      .zero_o    (count_zero)
   );

   assign prdata_o        = state.rdata;
   assign active_period_o = state.active;
   assign count_o         = count;
   assign count_zero_o    = count_zero;

   sequence s_period_write;
      access && pwrite_i && ce_i && addr_ofs == PWMPS_OFS_PERIOD;
   endsequence

   sequence s_period_read_setup;
      setup && !pwrite_i && ce_i && addr_ofs == PWMPS_OFS_PERIOD;
   endsequence

   a_shadow_write : assert property (
      @(posedge clk_sys_i) disable iff (!rst_n)
      (s_period_write and !state.load_select)
      |=> state.shadow == $past(pwdata_i[PERIOD_W-1:0]))
      else $error("shadow did not take the write");

   a_immediate_write : assert property (
      @(posedge clk_sys_i) disable iff (!rst_n)
      (s_period_write and state.load_select)
      |=> state.active == $past(pwdata_i[PERIOD_W-1:0])
          && state.shadow == $past(state.shadow))
      else $error("immediate write missed the active copy");

   a_zero_load : assert property (
      @(posedge clk_sys_i) disable iff (!rst_n)
      (ce_i && !state.load_select && count_zero)
      |=> state.active == $past(state.shadow))
      else $error("active not loaded at counter zero");

   a_active_held : assert property (
      @(posedge clk_sys_i) disable iff (!rst_n)
      (!state.load_select && !count_zero) |=> $stable(state.active))
      else $error("active copy changed outside counter zero");

   a_read_shadow : assert property (
      @(posedge clk_sys_i) disable iff (!rst_n)
      (s_period_read_setup ##0 !state.load_select)
      |=> prdata_o == PWMPS_DATA_W'($past(state.shadow)))
      else $error("period read did not return shadow");

   a_read_active : assert property (
      @(posedge clk_sys_i) disable iff (!rst_n)
      (s_period_read_setup ##0 state.load_select)
      |=> prdata_o == PWMPS_DATA_W'($past(state.active)))
      else $error("period read did not return active");

   a_reset_value : assert property (
      @(posedge clk_sys_i)
      (!rst_n) |-> (state.active == PWMPS_PERIOD_RST
                    && state.shadow == PWMPS_PERIOD_RST))
      else $error("period copies not zero in reset");

   a_unmapped_err : assert property (
      @(posedge clk_sys_i) disable iff (!rst_n)
      (access && addr_ofs != PWMPS_OFS_PERIOD
       && addr_ofs != PWMPS_OFS_CONTROL
       && addr_ofs != PWMPS_OFS_COUNTER) |-> pslverr_o)
      else $error("unmapped access without error");
endmodule
`default_nettype wire

// ===== tb/pwmps_tb.sv
// Testbench: APB accesses to the double-buffered time-base period register
`timescale 1ns/1ps
`default_nettype none
module tb
   import pwmps_pkg::*;
;
   localparam logic [31:0] c_run   = 32'h0000_0001 << PWMPS_CTL_RUN;
   localparam logic [31:0] c_ldsel = 32'h0000_0001 << PWMPS_CTL_LDSEL;

   logic        clk_sys_i;
   logic        resetn_i;
   logic        ce;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [15:0] active_period;
   logic [15:0] count;
   logic        count_zero;
   logic [31:0] rd;
   logic        err;
   int          n;
   int          mismatches;
   int          num_checks;

   // Clock enable driven so the frozen case is exercised
   pwmps_top #(.ADDR_W(12), .PERIOD_W(16)) dut
   (
      .clk_sys_i       (clk_sys_i),
      .resetn_i        (resetn_i),
      .ce_i            (ce),
      .psel_i          (psel),
      .penable_i       (penable),
      .pwrite_i        (pwrite),
      .paddr_i         (paddr),
      .pwdata_i        (pwdata),
      .prdata_o        (prdata),
      .pready_o        (pready),
      .pslverr_o       (pslverr),
      .active_period_o (active_period),
      .count_o         (count),
      .count_zero_o    (count_zero)
   );

   initial
   begin
      clk_sys_i = 1'b0;
      forever #2 clk_sys_i = ~clk_sys_i;
   end

   task automatic end_of_test;
      begin
         $display("checks=%0d mismatches=%0d", num_checks, mismatches);
         if (mismatches == 0 && num_checks > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      begin
         num_checks++;
         if (got !== exp)
         begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask

   // One APB transfer; returns settled just after the completing edge
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd);
      int k;
      begin
         k = 0;
         @(posedge clk_sys_i);
         psel    <= 1'b1;
         penable <= 1'b0;
         pwrite  <= wr;
         paddr   <= a;
         pwdata  <= wd;
         @(posedge clk_sys_i);
         penable <= 1'b1;
         @(posedge clk_sys_i);
         while (pready !== 1'b1 && k < 20)
         begin
            @(posedge clk_sys_i);
            k++;
         end
         if (k >= 20)
         begin
            mismatches++;
            end_of_test();
         end
         rd = prdata;
         err = pslverr;
         psel    <= 1'b0;
         penable <= 1'b0;
         #1;
      end
   endtask

   // Edges until the counter sits at zero again
   task automatic wait_zero(output int c);
      begin
         c = 0;
         do
         begin
            @(posedge clk_sys_i);
            #1;
            c++;
         end
         while (count_zero !== 1'b1 && c < 200);
         if (c >= 200)
         begin
            mismatches++;
            end_of_test();
         end
      end
   endtask

   initial
   begin
      mismatches = 0;
      num_checks = 0;
      resetn_i = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (20) @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      #1;
      chk({16'h0000, active_period}, 32'h0000_0000);
      apb(1'b0, PWMPS_OFS_PERIOD, 32'h0);
      chk(rd, 32'h0000_0000);
      apb(1'b0, PWMPS_OFS_CONTROL, 32'h0);
      chk(rd & c_ldsel, 32'h0000_0000);
      // Stopped at zero the shadow loads every cycle
      apb(1'b1, PWMPS_OFS_PERIOD, 32'h0000_0040);
      @(posedge clk_sys_i);
      #1;
      chk({16'h0000, active_period}, 32'h0000_0040);
      apb(1'b1, PWMPS_OFS_CONTROL, c_run);
      apb(1'b1, PWMPS_OFS_PERIOD, 32'h0000_0005);
      chk({31'h0, err}, 32'h0000_0000);
      chk({16'h0000, active_period}, 32'h0000_0040);
      apb(1'b0, PWMPS_OFS_PERIOD, 32'h0);
      chk(rd, 32'h0000_0005);
      chk({16'h0000, active_period}, 32'h0000_0040);
      wait_zero(n);
      wait_zero(n);
      chk({16'h0000, active_period}, 32'h0000_0005);
      chk(n, 32'd6);
      // Immediate mode: a write governs the counter at once
      apb(1'b1, PWMPS_OFS_CONTROL, c_run | c_ldsel);
      apb(1'b1, PWMPS_OFS_PERIOD, 32'h0000_0003);
      chk({16'h0000, active_period}, 32'h0000_0003);
      apb(1'b0, PWMPS_OFS_PERIOD, 32'h0);
      chk(rd, 32'h0000_0003);
      wait_zero(n);
      wait_zero(n);
      chk(n, 32'd4);
      // Back to shadowed; upper half of the word is dropped
      apb(1'b1, PWMPS_OFS_CONTROL, c_run);
      apb(1'b1, PWMPS_OFS_PERIOD, 32'hABCD_0008);
      apb(1'b0, PWMPS_OFS_PERIOD, 32'h0);
      chk(rd, 32'h0000_0008);
      wait_zero(n);
      wait_zero(n);
      chk({16'h0000, active_period}, 32'h0000_0008);
      wait_zero(n);
      chk(n, 32'd9);
      // Enable low freezes the counter and stalls a read
      @(posedge clk_sys_i);
      ce <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      #1;
      chk({16'h0000, count}, 32'h0000_0001);
      fork
         apb(1'b0, PWMPS_OFS_PERIOD, 32'h0);
         begin
            repeat (6) @(posedge clk_sys_i);
            ce <= 1'b1;
         end
      join
      chk(rd, 32'h0000_0008);
      // Stopped counter holds; its register matches the pin
      apb(1'b1, PWMPS_OFS_CONTROL, 32'h0);
      apb(1'b0, PWMPS_OFS_COUNTER, 32'h0);
      chk(rd, 32'h0000_0006);
      chk({16'h0000, count}, 32'h0000_0006);
      apb(1'b1, 12'h00C, 32'h0000_FFFF);
      chk({31'h0, err}, 32'h0000_0001);
      apb(1'b0, 12'h00C, 32'h0);
      chk({31'h0, err}, 32'h0000_0001);
      chk(rd, 32'h0000_0000);
      chk({16'h0000, active_period}, 32'h0000_0008);
      end_of_test();
   end
endmodule
`default_nettype wire
